/* hdl/dcc_timer.sv */
// dcc_timer: two-channel 16-bit capture/compare timer with prescaler
// assumes: control bits are plain ports held stable by software logic;
// value writes are one-cycle strobes on ref_clk_i; pins are asynchronous
//
// How it works
// - a 16-bit counter runs free or counts up modulo a programmed value
// - the modulo value sets the terminal count when nonzero
// - the counter value is always visible and reading never disturbs it
// - each channel is separately an input capture or output compare channel
// - a three-bit select picks seven bus clock rates or the external clock
// - an active capture edge copies the counter into the channel value
// - capture edge is rising only, falling only, or either edge
// - a capture event can raise that channel's interrupt request
// - a compare match sets, clears or toggles the channel pin
// - a compare match can raise that channel's interrupt request
// - unbuffered writes replace the active compare value immediately
// - compare flag sets at the match tick; overflow flag at rollover
// - the link select on channel 0 joins both channels onto pin 0
// - linked: channel 0 controls first, channel 1 after its write and overflow
// - linked: at each overflow the last written channel takes control
// - linked: channel 0 controls and reports, channel 1 pin goes to port
// - toggle-on-overflow flips the compare pin at each rollover
// - stop and reset controls halt and clear the counter
// - overflow flag sets at rollover; request only with its enable
// - channel flag sets on each event; request only with its enable
`timescale 1ns/1ps
`default_nettype none
module dcc_timer
  import dcc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // counter control
  input wire logic counter_stop_i,
  input wire logic counter_reset_i,
  input wire logic [dcc_pkg::PS_W-1:0] prescaler_select_i,
  input wire logic [dcc_pkg::CNT_W-1:0] modulo_value_i,
  input wire logic overflow_irq_enable_i,
  input wire logic overflow_flag_clear_i,
  // channel control, index 0 and 1
  input wire logic [1:0] channel_compare_mode_i,
  input wire logic link_buffered_select_i,
  input wire logic [1:0] channel_edge_a_i,
  input wire logic [1:0] channel_edge_b_i,
  input wire logic [1:0] channel_toggle_overflow_i,
  input wire logic [1:0] channel_irq_enable_i,
  input wire logic [1:0] channel_event_flag_clear_i,
  // channel value writes
  input wire logic [1:0] channel_value_write_i,
  input wire logic [dcc_pkg::CNT_W-1:0] channel_value_wdata_i,
  // pins
  input wire logic external_timer_clock_pin_i,
  input wire logic channel0_pin_i,
  input wire logic channel1_pin_i,
  output logic channel0_pin_o,
  output logic channel0_pin_oe_o,
  output logic channel1_pin_o,
  output logic channel1_pin_oe_o,
  // status
  output logic [dcc_pkg::CNT_W-1:0] counter_value_o,
  output logic [dcc_pkg::CNT_W-1:0] channel0_value_o,
  output logic [dcc_pkg::CNT_W-1:0] channel1_value_o,
  output logic overflow_flag_o,
  output logic [1:0] channel_event_flag_o,
  output logic overflow_irq_o,
  output logic [1:0] channel_irq_o,
  output logic active_channel_o
);
  import dcc_pkg::*;

  // edge test for the capture select bits: a for rising, b for falling
  function automatic logic el_edge(input logic a, input logic b,
                                   input logic cur, input logic prev);
    el_edge = (a && cur && !prev) || (b && !cur && prev);
  endfunction

  function automatic logic pin_action(input logic a, input logic b,
                                      input logic pin);
    if (a && b) begin
      pin_action = 1'b1;
    end else if (b) begin
      pin_action = 1'b0;
    end else begin
      pin_action = !pin;
    end
  endfunction

  logic ext_sync;
  logic ch0_sync;
  logic ch1_sync;

  // every pin crosses two flops before logic sees it
  dcc_sync u_sync_ext (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .d_i(external_timer_clock_pin_i),
    .q_o(ext_sync)
  );
  dcc_sync u_sync_ch0 (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .d_i(channel0_pin_i),
    .q_o(ch0_sync)
  );
  dcc_sync u_sync_ch1 (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .d_i(channel1_pin_i),
    .q_o(ch1_sync)
  );

  logic [6:0] prescale;
  logic ext_prev;
  logic [1:0] pin_prev;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] chan_val [2];
  logic [1:0] chan_pin;
  logic ov_flag;
  logic [1:0] ev_flag;
  logic active;
  logic pending_swap;
  logic pending_to;

  logic [6:0] next_prescale;
  logic next_ext_prev;
  logic [1:0] next_pin_prev;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] next_chan_val [2];
  logic [1:0] next_chan_pin;
  logic next_ov_flag;
  logic [1:0] next_ev_flag;
  logic next_active;
  logic next_pending_swap;
  logic next_pending_to;

  logic tick;
  logic wrap;
  logic [1:0] pin_now;
  logic [1:0] is_cmp;
  logic [1:0] cap_ev;
  logic [1:0] cmp_ev;
  logic [CNT_W-1:0] cmp_val0;
  logic [6:0] pre_sum;
  logic linked;

  always_comb begin
    // select tick from prescaler tap or synchronised external edge
    next_prescale = prescale;
    next_ext_prev = ext_sync;
    pre_sum = prescale + PRE_ONE;
    tick = 1'b0;
    if (prescaler_select_i == PS_EXT) begin
      tick = ext_sync && !ext_prev;
    end else if (prescaler_select_i == 3'h0) begin
      tick = 1'b1;
    end else begin
      // divide by 2^ps: tick when low ps bits of the next value are zero
      tick = (pre_sum & ((PRE_ONE << prescaler_select_i) - PRE_ONE)) == PRE_ZERO;
    end
    if (!counter_stop_i) begin
      next_prescale = pre_sum;
    end
    if (counter_stop_i) begin
      tick = 1'b0;
    end
    if (counter_reset_i) begin
      next_prescale = PRE_ZERO;
      tick = 1'b0;
    end
  end

  always_comb begin
    linked = link_buffered_select_i;
    is_cmp = channel_compare_mode_i | {1'b0, linked};
    pin_now = {ch1_sync, ch0_sync};
    next_pin_prev = pin_now;
    // modulo of zero means free running over the full range
    wrap = tick && (modulo_value_i != MOD_FREE) && (count == modulo_value_i);
    if (tick && (modulo_value_i == MOD_FREE) && (count == {CNT_W{1'b1}})) begin
      wrap = 1'b1;
    end
    next_count = count;
    if (wrap) begin
      next_count = CNT_ZERO;
    end else if (tick) begin
      next_count = count + CNT_ONE;
    end
    if (counter_reset_i) begin
      next_count = CNT_ZERO;
    end
    cmp_val0 = linked ? chan_val[active] : chan_val[0];
    for (int i = 0; i < 2; i++) begin
      cap_ev[i] = !is_cmp[i] &&
                  el_edge(channel_edge_a_i[i], channel_edge_b_i[i], pin_now[i],
                          pin_prev[i]);
    end
    // a linked pair keeps channel 1 as buffer, so its pin must not capture into it
    cap_ev[1] = cap_ev[1] && !linked;
    cmp_ev[0] = is_cmp[0] && tick && (count == cmp_val0);
    cmp_ev[1] = is_cmp[1] && !linked && tick && (count == chan_val[1]);
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_chan_val[i] = chan_val[i];
      if (channel_value_write_i[i]) begin
        next_chan_val[i] = channel_value_wdata_i;
      end
      if (cap_ev[i]) begin
        next_chan_val[i] = count;
      end
    end
    // linked pair: remember last written channel, hand over at rollover
    next_active = active;
    next_pending_swap = pending_swap;
    next_pending_to = pending_to;
    if (linked) begin
      if (channel_value_write_i[1]) begin
        next_pending_swap = 1'b1;
        next_pending_to = 1'b1;
      end else if (channel_value_write_i[0]) begin
        next_pending_swap = 1'b1;
        next_pending_to = 1'b0;
      end
      if (wrap && pending_swap) begin
        next_active = pending_to;
        next_pending_swap = channel_value_write_i != 2'b00;
      end
    end else begin
      next_active = 1'b0;
      next_pending_swap = 1'b0;
      next_pending_to = 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_chan_pin[i] = chan_pin[i];
      // overflow toggle wins over a simultaneous compare
      if (is_cmp[i] && wrap && channel_toggle_overflow_i[i]) begin
        next_chan_pin[i] = !chan_pin[i];
      end else if (cmp_ev[i]) begin
        next_chan_pin[i] = pin_action(channel_edge_a_i[i], channel_edge_b_i[i],
                                      chan_pin[i]);
      end
    end
    // set wins over clear
    next_ov_flag = (ov_flag && !overflow_flag_clear_i) || wrap;
    next_ev_flag = (ev_flag & ~channel_event_flag_clear_i) | cap_ev | cmp_ev;
    if (linked) begin
      next_ev_flag[1] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prescale <= PRE_ZERO;
      ext_prev <= 1'b0;
      pin_prev <= 2'b00;
      count <= CNT_ZERO;
      chan_val[0] <= CNT_ZERO;
      chan_val[1] <= CNT_ZERO;
      chan_pin <= 2'b00;
      ov_flag <= 1'b0;
      ev_flag <= 2'b00;
      active <= 1'b0;
      pending_swap <= 1'b0;
      pending_to <= 1'b0;
    end else begin
      prescale <= next_prescale;
      ext_prev <= next_ext_prev;
      pin_prev <= next_pin_prev;
      count <= next_count;
      chan_val[0] <= next_chan_val[0];
      chan_val[1] <= next_chan_val[1];
      chan_pin <= next_chan_pin;
      ov_flag <= next_ov_flag;
      ev_flag <= next_ev_flag;
      active <= next_active;
      pending_swap <= next_pending_swap;
      pending_to <= next_pending_to;
    end
  end

  // outputs registered from next values, so they track state exactly
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      counter_value_o <= CNT_ZERO;
      channel0_value_o <= CNT_ZERO;
      channel1_value_o <= CNT_ZERO;
      overflow_flag_o <= 1'b0;
      channel_event_flag_o <= 2'b00;
      overflow_irq_o <= 1'b0;
      channel_irq_o <= 2'b00;
      active_channel_o <= 1'b0;
      channel0_pin_o <= 1'b0;
      channel0_pin_oe_o <= 1'b0;
      channel1_pin_o <= 1'b0;
      channel1_pin_oe_o <= 1'b0;
    end else begin
      counter_value_o <= next_count;
      channel0_value_o <= next_chan_val[0];
      channel1_value_o <= next_chan_val[1];
      overflow_flag_o <= next_ov_flag;
      channel_event_flag_o <= next_ev_flag;
      overflow_irq_o <= next_ov_flag && overflow_irq_enable_i;
      channel_irq_o <= next_ev_flag & channel_irq_enable_i;
      active_channel_o <= next_active;
      channel0_pin_o <= next_chan_pin[0];
      channel0_pin_oe_o <= is_cmp[0] &&
                           ((channel_edge_a_i[0] | channel_edge_b_i[0]) == 1'b1);
      channel1_pin_o <= next_chan_pin[1];
      channel1_pin_oe_o <= is_cmp[1] && !linked &&
                           ((channel_edge_a_i[1] | channel_edge_b_i[1]) == 1'b1);
    end
  end
endmodule
`default_nettype wire

/* hdl/dcc_pkg.sv */
// dcc_pkg: constants and types shared by the dual capture/compare timer
// assumes: single bus clock domain, 16-bit counter, two channels
package dcc_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PS_W = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] MOD_FREE = 16'h0000;
  localparam logic [6:0] PRE_ZERO = 7'h00;
  localparam logic [6:0] PRE_ONE = 7'h01;
  localparam logic [PS_W-1:0] PS_EXT = 3'h7;

  // channel edge/level select, as two bits per channel
  typedef enum logic [1:0] {
    DCC_EL_PORT = 2'b00,
    DCC_EL_A = 2'b01,
    DCC_EL_B = 2'b10,
    DCC_EL_AB = 2'b11
  } dcc_el_e;
  // input capture: A rising, B falling, AB either
  // output compare: A toggle, B clear, AB set
endpackage

/* hdl/dcc_sync.sv */
// dcc_sync: two-flop synchroniser for one asynchronous level
// assumes: d_i comes from outside the ref_clk_i domain
`timescale 1ns/1ps
`default_nettype none
module dcc_sync (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // level
  input wire logic d_i,
  output logic q_o
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule
`default_nettype wire

/* testbench/dcc_timer_chk.sv */
// dcc_timer_chk: port-level assertions for the capture/compare timer
// assumes: bound into dcc_timer; one clock domain, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module dcc_timer_chk (
  // clock, reset and controls
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic counter_stop_i,
  input wire logic counter_reset_i,
  input wire logic [2:0] prescaler_select_i,
  input wire logic [15:0] modulo_value_i,
  input wire logic [1:0] channel_compare_mode_i,
  input wire logic link_buffered_select_i,
  input wire logic [1:0] channel_edge_a_i,
  input wire logic [1:0] channel_edge_b_i,
  input wire logic [1:0] channel_toggle_overflow_i,
  input wire logic [1:0] channel_value_write_i,
  // observed outputs
  input wire logic channel0_pin_o,
  input wire logic channel1_pin_oe_o,
  input wire logic [15:0] counter_value_o,
  input wire logic [15:0] channel0_value_o,
  input wire logic overflow_flag_o,
  input wire logic [1:0] channel_event_flag_o,
  input wire logic overflow_irq_o,
  input wire logic [1:0] channel_irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // undivided clock and counter free to move
  sequence s_run;
    prescaler_select_i == 3'h0 && !counter_stop_i && !counter_reset_i;
  endsequence
  sequence s_wrap;
    s_run ##0 (modulo_value_i != 16'h0000 && counter_value_o == modulo_value_i);
  endsequence
  // a toggle compare on channel 0 with no overflow toggle competing
  sequence s_cmp0;
    s_run ##0 (channel_compare_mode_i[0] && !link_buffered_select_i && channel_edge_a_i[0]
      && !channel_edge_b_i[0] && !channel_toggle_overflow_i[0] && !channel_value_write_i[0]
      && counter_value_o == channel0_value_o);
  endsequence
  wrap_zero_a: assert property (s_wrap |=> counter_value_o == 16'h0000 && overflow_flag_o)
    else $error("counter did not wrap with overflow flag");
  count_step_a: assert property (s_run ##0 counter_value_o != modulo_value_i
    |=> counter_value_o == $past(counter_value_o) + 16'h0001)
    else $error("counter did not step by one");
  stop_hold_a: assert property (counter_stop_i && !counter_reset_i
    |=> $stable(counter_value_o))
    else $error("counter moved while stopped");
  clear_zero_a: assert property (counter_reset_i |=> counter_value_o == 16'h0000)
    else $error("counter not cleared");
  ovf_irq_a: assert property (overflow_irq_o |-> overflow_flag_o)
    else $error("overflow request without flag");
  chan_irq_a: assert property (channel_irq_o[0] |-> channel_event_flag_o[0])
    else $error("channel request without flag");
  cmp_toggle_a: assert property (s_cmp0
    |=> channel0_pin_o != $past(channel0_pin_o) && channel_event_flag_o[0])
    else $error("compare match did not toggle pin");
  link_free_a: assert property (link_buffered_select_i [*2] |-> !channel1_pin_oe_o)
    else $error("channel 1 pin driven while linked");
endmodule
`default_nettype wire

/* testbench/dcc_pin_env.sv */
// dcc_pin_env: event sources and loads on the timer's pins
// assumes: called from the bench at falling clock edges
`timescale 1ns/1ps
`default_nettype none
module dcc_pin_env (
  // clock
  input wire logic ref_clk_i,
  // device side of the channel pins
  input wire logic channel0_pin_o,
  input wire logic channel0_pin_oe_o,
  input wire logic channel1_pin_o,
  input wire logic channel1_pin_oe_o,
  // levels seen by the device
  output logic ext_clk_o,
  output logic pin0_o,
  output logic pin1_o
);
  logic [1:0] src = 2'h0;
  initial ext_clk_o = 1'b0;
  // the device wins the wire while it drives, else the event source shows
  assign pin0_o = channel0_pin_oe_o ? channel0_pin_o : src[0];
  assign pin1_o = channel1_pin_oe_o ? channel1_pin_o : src[1];
  task automatic drive(input int ch, input logic v);
    @(negedge ref_clk_i);
    src[ch] = v;
  endtask
  // external clock stays low between bursts; halves of 4 cycles suit the synchroniser
  task automatic ext(input int n);
    repeat (n) begin
      ext_clk_o = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      ext_clk_o = 1'b0;
      repeat (4) @(negedge ref_clk_i);
    end
  endtask
endmodule
`default_nettype wire

/* testbench/dcc_timer_tb.sv */
// dcc_timer_tb: directed bench for the capture/compare timer
// assumes: dcc_pkg, dcc_timer, dcc_pin_env and dcc_timer_chk compiled first
`timescale 1ns/1ps
`default_nettype none
module dcc_timer_tb;
  import dcc_pkg::*;
  logic ref_clk_i, reset_n_i, counter_stop_i, counter_reset_i, overflow_irq_enable_i;
  logic overflow_flag_clear_i, link_buffered_select_i, external_timer_clock_pin_i;
  logic [PS_W-1:0] prescaler_select_i;
  logic [CNT_W-1:0] modulo_value_i, channel_value_wdata_i;
  logic [1:0] channel_compare_mode_i, channel_edge_a_i, channel_edge_b_i, channel_irq_enable_i;
  logic [1:0] channel_toggle_overflow_i, channel_event_flag_clear_i, channel_value_write_i;
  logic channel0_pin_i, channel1_pin_i, channel0_pin_o, channel0_pin_oe_o, channel1_pin_o;
  logic channel1_pin_oe_o, overflow_flag_o, overflow_irq_o, active_channel_o, p;
  logic [CNT_W-1:0] counter_value_o, channel0_value_o, channel1_value_o;
  logic [1:0] channel_event_flag_o, channel_irq_o;
  int err_count = 0;
  int tests_run = 0;
  int n;
  dcc_timer uut (.*);
  dcc_pin_env env (.ref_clk_i, .channel0_pin_o, .channel0_pin_oe_o, .channel1_pin_o,
    .channel1_pin_oe_o, .ext_clk_o(external_timer_clock_pin_i), .pin0_o(channel0_pin_i),
    .pin1_o(channel1_pin_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask
  task automatic wr(input int ch, input logic [15:0] d);
    channel_value_write_i[ch] = 1'b1;
    channel_value_wdata_i = d;
    cyc(1);
    channel_value_write_i = 2'h0;
  endtask
  task automatic clr();
    channel_event_flag_clear_i = 2'h3;
    cyc(1);
    channel_event_flag_clear_i = 2'h0;
  endtask
  // restart the counter from zero and let it run
  task automatic restart();
    counter_reset_i = 1'b1;
    cyc(1);
    {counter_reset_i, counter_stop_i} = 2'h0;
  endtask
  // bounded wait for the channel 0 flag (ovf 0) or the overflow flag (ovf 1)
  task automatic wait_flag(input int ovf);
    int k;
    k = 0;
    while (k < 20 && (ovf != 0 ? overflow_flag_o : channel_event_flag_o[0]) !== 1'b1) begin
      cyc(1);
      k++;
    end
    if (k == 20) begin
      err_count++;
      $display("[ERR] flag wait expected 1 seen 0");
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    end_of_test();
  end
  initial begin
    {reset_n_i, counter_stop_i, counter_reset_i, overflow_irq_enable_i} = 4'h6;
    {overflow_flag_clear_i, link_buffered_select_i, prescaler_select_i} = 5'h00;
    {modulo_value_i, channel_value_wdata_i} = 32'h0000_0000;
    {channel_compare_mode_i, channel_edge_a_i, channel_edge_b_i} = 6'h00;
    {channel_toggle_overflow_i, channel_irq_enable_i} = 4'h0;
    {channel_event_flag_clear_i, channel_value_write_i} = 4'h0;
    cyc(4);
    reset_n_i = 1'b1;
    chk("count", 16'h0000, counter_value_o);
    cyc(1);
    restart();
    cyc(20);
    counter_stop_i = 1'b1;
    cyc(3);
    chk("count", 16'h0014, counter_value_o);
    for (int m = 1; m < 4; m++) begin
      channel_edge_a_i[0] = m[0];
      channel_edge_b_i[0] = m[1];
      clr();
      env.drive(0, 1'b1);
      cyc(5);
      chk("rise flag", 16'(m[0]), 16'(channel_event_flag_o[0]));
      clr();
      env.drive(0, 1'b0);
      cyc(5);
      chk("fall flag", 16'(m[1]), 16'(channel_event_flag_o[0]));
    end
    chk("capture", 16'h0014, channel0_value_o);
    channel_irq_enable_i = 2'h1;
    cyc(2);
    chk("cap irq", 16'h0001, 16'(channel_irq_o[0]));
    channel_irq_enable_i = 2'h0;
    cyc(2);
    chk("cap irq", 16'h0000, 16'(channel_irq_o[0]));
    modulo_value_i = 16'h0003;
    restart();
    for (int i = 1; i < 9; i++) begin
      cyc(1);
      chk("mod count", 16'(i % 4), counter_value_o);
    end
    counter_stop_i = 1'b1;
    chk("ovf flag", 16'h0001, 16'(overflow_flag_o));
    chk("ovf irq", 16'h0000, 16'(overflow_irq_o));
    overflow_irq_enable_i = 1'b1;
    cyc(2);
    chk("ovf irq", 16'h0001, 16'(overflow_irq_o));
    overflow_flag_clear_i = 1'b1;
    cyc(1);
    overflow_flag_clear_i = 1'b0;
    cyc(1);
    chk("ovf flag", 16'h0000, 16'(overflow_flag_o));
    modulo_value_i = MOD_FREE;
    // prescaler phase after a clear may cost one tick, so 7 or 8 ticks pass
    for (int s = 0; s < 7; s++) begin
      prescaler_select_i = 3'(s);
      restart();
      cyc(8 << s);
      counter_stop_i = 1'b1;
      cyc(1);
      chk("scaled", 16'h0001, 16'(counter_value_o inside {16'h0007, 16'h0008}));
    end
    prescaler_select_i = PS_EXT;
    restart();
    env.ext(5);
    cyc(6);
    chk("ext count", 16'h0005, counter_value_o);
    prescaler_select_i = 3'h0;
    modulo_value_i = 16'h0007;
    channel_compare_mode_i = 2'h3;
    channel_irq_enable_i = 2'h1;
    wr(0, 16'h0005);
    clr();
    for (int m = 3; m > 0; m--) begin
      channel_edge_a_i[0] = m[0];
      channel_edge_b_i[0] = m[1];
      cyc(8);
      chk("cmp pin", 16'(m != 2), 16'(channel0_pin_o));
    end
    chk("cmp oe", 16'h0001, 16'(channel0_pin_oe_o));
    chk("cmp irq", 16'h0001, 16'(channel_irq_o[0]));
    channel_toggle_overflow_i = 2'h1;
    {channel_edge_b_i[0], channel_edge_a_i[0]} = 2'h3;
    n = 0;
    p = channel0_pin_o;
    repeat (16) begin
      cyc(1);
      if (channel0_pin_o !== p) n++;
      p = channel0_pin_o;
    end
    chk("pwm edges", 16'h0004, 16'(n));
    channel_toggle_overflow_i = 2'h0;
    channel_irq_enable_i = 2'h3;
    {channel_edge_b_i[1], channel_edge_a_i[1]} = 2'h3;
    cyc(8);
    chk("ch1 oe", 16'h0001, 16'(channel1_pin_oe_o));
    chk("ch1 pin", 16'h0001, 16'(channel1_pin_o));
    chk("ch1 irq", 16'h0001, 16'(channel_irq_o[1]));
    link_buffered_select_i = 1'b1;
    cyc(2);
    chk("ch1 oe", 16'h0000, 16'(channel1_pin_oe_o));
    chk("ch1 flag", 16'h0000, 16'(channel_event_flag_o[1]));
    chk("active", 16'h0000, 16'(active_channel_o));
    wr(1, 16'h0002);
    chk("ch1 value", 16'h0002, channel1_value_o);
    cyc(10);
    chk("active", 16'h0001, 16'(active_channel_o));
    wr(0, 16'h0006);
    cyc(10);
    chk("active", 16'h0000, 16'(active_channel_o));
    // unbuffered updates on a toggling channel 0, modulo 7, value 6 active
    link_buffered_select_i = 1'b0;
    {channel_toggle_overflow_i, channel_edge_b_i, channel_edge_a_i} = 6'h01;
    clr();
    wait_flag(0);
    wr(0, 16'h0002);
    clr();
    wait_flag(0);
    chk("cmp at 2", 16'h0003, counter_value_o);
    overflow_flag_clear_i = 1'b1;
    cyc(1);
    overflow_flag_clear_i = 1'b0;
    wait_flag(1);
    wr(0, 16'h0006);
    clr();
    wait_flag(0);
    chk("cmp at 6", 16'h0007, counter_value_o);
    overflow_flag_clear_i = 1'b1;
    cyc(1);
    overflow_flag_clear_i = 1'b0;
    wait_flag(1);
    cyc(2);
    // the counter has passed the new value and not yet reached the old one
    wr(0, 16'h0001);
    clr();
    cyc(4);
    chk("missed cmp", 16'h0000, 16'(channel_event_flag_o[0]));
    wait_flag(0);
    chk("cmp at 1", 16'h0002, counter_value_o);
    end_of_test();
  end
endmodule
bind dcc_timer dcc_timer_chk chk_i (.*);
`default_nettype wire
